// [rtl/uart_chan.sv]
// One asynchronous serial channel with FIFOs, baud generator and APB slave
`timescale 1ns/1ps

module uart_chan
  import uart_chan_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       psel_i,
  input  wire logic       penable_i,
  input  wire logic       pwrite_i,
  input  wire logic [4:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]     prdata_o,
  output logic            pready_o,
  output logic            pslverr_o,
  input  wire logic       osc_in_pin_i,
  input  wire logic       rx_i,
  output logic            tx_o,
  output logic            chan_a_irq_pin_o
);

  localparam int PW = $clog2(DEPTH);

  // Trigger level 14 and pointer wrap need a power of two of 16 or more
  if (DEPTH < 16 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("uart_chan: DEPTH must be a power of two of at least 16");
  end

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_START = 5'b00010,
    S_DATA  = 5'b00100,
    S_PAR   = 5'b01000,
    S_STOP  = 5'b10000
  } ser_state_t;

  // Mask of the active data bits for a word length code
  function automatic logic [7:0] word_mask(input logic [1:0] w);
    word_mask = 8'hFF >> (2'h3 - w);
  endfunction

  // Timeout limit in sampling ticks: four words plus twelve bits
  function automatic logic [10:0] tout_limit(input logic [1:0] w);
    int bits;
    bits = TOUT_WORDS * (5 + int'(w)) + TOUT_EXTRA;
    tout_limit = 11'(bits * TICKS_BIT);
  endfunction

  // Registers
  logic [7:0]     ier_q, lcr_q, fcr_q, dll_q, dlm_q, tsh_q, rsh_q;
  logic           osc_s1_q, osc_s2_q, osc_s3_q, rx_s1_q, rx_s2_q;
  logic [15:0]    bcnt_q;
  logic [7:0]     txm_q [DEPTH];
  logic [10:0]    rxm_q [DEPTH];
  logic [PW-1:0]  twp_q, trp_q, rwp_q, rrp_q;
  logic [PW:0]    tcnt_q, rcnt_q;
  ser_state_t     ts_q, rs_q;
  logic [3:0]     tsub_q, rsub_q;
  logic [2:0]     tbit_q, rbit_q;
  logic [10:0]    tocnt_q;
  logic [31:0]    prdata_q;
  logic           tick_q, tpar_q, tstop2_q, tx_q, rpe_q, ovr_q, tof_q;
  logic           pready_q, pslverr_q, irq_q;

  // Bus decode: setup phase latches answer, access completes with pready
  wire       setup   = psel_i & ~penable_i;
  wire       done    = psel_i & penable_i & pready_q;
  wire       wr_done = done & pwrite_i;
  wire       rd_done = done & ~pwrite_i;
  wire       a_data  = paddr_i == OFS_DATA;
  wire       a_ier   = paddr_i == OFS_IER;
  wire       a_isr   = paddr_i == OFS_ISR;
  wire       a_lcr   = paddr_i == OFS_LCR;
  wire       a_lsr   = paddr_i == OFS_LSR;
  wire       a_dll   = paddr_i == OFS_DLL;
  wire       a_dlm   = paddr_i == OFS_DLM;
  wire       mapped  = a_data | a_ier | a_isr | a_lcr | a_lsr | a_dll | a_dlm;
  wire [7:0] wbyte   = pwdata_i[7:0];
  wire       fcr_wr  = wr_done & a_isr;
  wire       fifo_en = fcr_q[FCR_EN];
  // Toggling FIFO enable flushes both FIFOs; each reset bit flushes its own FIFO
  wire       en_chg  = fcr_wr & (wbyte[FCR_EN] != fifo_en);
  wire       rx_clr  = fcr_wr & (wbyte[FCR_RXRS] | en_chg);
  wire       tx_clr  = fcr_wr & (wbyte[FCR_TXRS] | en_chg);

  // Baud generator: divisor from high and low bytes, zero halts it
  wire [15:0] divisor = {dlm_q, dll_q};
  wire        div_on  = divisor != 16'h0000;
  wire        osc_edge = osc_s2_q & ~osc_s3_q;

  // Transmit FIFO status; non-FIFO mode holds one byte only
  wire [PW:0] cap      = fifo_en ? (PW+1)'(DEPTH) : (PW+1)'(1);
  wire        tx_push  = wr_done & a_data & (tcnt_q < cap);
  wire        tx_empty = tcnt_q == '0;
  wire        tx_load  = (ts_q == S_IDLE) & ~tx_empty & div_on;
  wire        tsr_idle = (ts_q == S_IDLE) & ~tx_load;
  wire        lsr_thre = tx_empty;
  wire        lsr_temt = tx_empty & tsr_idle;
  wire [7:0]  tx_head  = txm_q[trp_q];
  wire [7:0]  wm       = word_mask(lcr_q[LCR_WLEN +: 2]);
  wire        tbit_end = tick_q & (tsub_q == TICKS_LAST);

  // Receive side status and tags of the head entry
  wire        rx_have  = rcnt_q != '0;
  wire [10:0] rx_head  = rx_have ? rxm_q[rrp_q] : 11'h000;
  wire        rx_pop   = rd_done & a_data & rx_have;
  wire        rsample  = tick_q & (rsub_q == TICKS_LAST);
  wire        rmid     = tick_q & (rsub_q == TICK_MID);
  wire [7:0]  rdat     = rsh_q & wm;
  wire        fe_now   = ~rx_s2_q;
  wire        brk_now  = (rdat == 8'h00) & ~rx_s2_q & ~rpe_q;
  wire        rx_done  = (rs_q == S_STOP) & rsample;
  wire        rx_full  = rcnt_q >= cap;
  wire        rx_push  = rx_done & ~rx_full;
  wire        ovr_set  = rx_done & rx_full;
  wire        ovr_clr  = rd_done & a_lsr;

  // Trigger level and interrupt sources
  logic [4:0] trig;
  always_comb begin
    case (fcr_q[FCR_TRG +: 2])
      2'h0:    trig = TRG_LVL0;
      2'h1:    trig = TRG_LVL1;
      2'h2:    trig = TRG_LVL2;
      default: trig = TRG_LVL3;
    endcase
  end
  wire rx_lvl  = fifo_en ? ((PW+1)'(trig) <= rcnt_q) : rx_have;
  wire rls_irq = ier_q[IER_RLS] & (ovr_q | |rx_head[10:8]);
  wire rxd_irq = ier_q[IER_RXD] & rx_lvl;
  wire to_irq  = ier_q[IER_RXD] & tof_q;
  wire the_irq = ier_q[IER_THE] & lsr_thre;
  wire [3:0] isr_code = rls_irq ? ISR_RLS  :
                        rxd_irq ? ISR_RXD  :
                        to_irq  ? ISR_TOUT :
                        the_irq ? ISR_THE  : ISR_NONE;
  wire [7:0] isr_val  = {fifo_en, fifo_en, 2'b00, isr_code};
  wire [7:0] lsr_val  = {1'b0, lsr_temt, lsr_thre, rx_head[10:8],
                         ovr_q, rx_have};

  // Read data selection; bus runs on clock_i alone
  wire [7:0] rd_sel = a_data ? rx_head[7:0] :
                      a_ier  ? ier_q :
                      a_isr  ? isr_val :
                      a_lcr  ? lcr_q :
                      a_lsr  ? lsr_val :
                      a_dll  ? dll_q :
                      a_dlm  ? dlm_q : 8'h00;

  // APB answer: ready in the first cycle of the access phase, never stalls
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q  <= {24'h00_0000, rd_sel};
        pslverr_q <= ~mapped;
      end
    end
  end

  // Software registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ier_q <= IER_RST;
      lcr_q <= LCR_RST;
      fcr_q <= FCR_RST;
      dll_q <= DIV_RST;
      dlm_q <= DIV_RST;
    end else if (wr_done) begin
      if (a_ier) ier_q <= {5'h00, wbyte[2:0]};
      if (a_lcr) lcr_q <= wbyte;
      if (a_isr) fcr_q <= {wbyte[7:6], 5'h00, wbyte[0]};
      if (a_dll) dll_q <= wbyte;
      if (a_dlm) dlm_q <= wbyte;
    end
  end

  // Synchronisers for the oscillator and receive pins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      {osc_s1_q, osc_s2_q, osc_s3_q} <= 3'b000;
      {rx_s1_q, rx_s2_q}             <= 2'b11;
    end else begin
      osc_s1_q <= osc_in_pin_i;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      rx_s1_q  <= rx_i;
      rx_s2_q  <= rx_s1_q;
    end
  end

  // Divide oscillator edges by the divisor into the 16x tick; one tick
  // feeds both directions so they always share the rate
  always_ff @(posedge clock_i) begin
    if (rst_i || !div_on) begin
      bcnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (osc_edge) begin
        if (bcnt_q >= divisor - 16'h0001) begin
          bcnt_q <= 16'h0000;
          tick_q <= 1'b1;
        end else begin
          bcnt_q <= bcnt_q + 16'h0001;
        end
      end
    end
  end

  // Transmit FIFO storage
  always_ff @(posedge clock_i) begin
    if (tx_push) txm_q[twp_q] <= wbyte;
  end

  // Transmit FIFO pointers
  always_ff @(posedge clock_i) begin
    if (rst_i || tx_clr) begin
      twp_q  <= '0;
      trp_q  <= '0;
      tcnt_q <= '0;
    end else begin
      if (tx_push) twp_q <= twp_q + PW'(1);
      if (tx_load) trp_q <= trp_q + PW'(1);
      tcnt_q <= tcnt_q + (PW+1)'(tx_push) - (PW+1)'(tx_load);
    end
  end

  // Transmit shifter: start, data LSB first, parity, stop bits
  always_ff @(posedge clock_i) begin
    if (rst_i || !div_on) begin
      ts_q     <= S_IDLE;
      tsub_q   <= 4'h0;
      tbit_q   <= 3'h0;
      tsh_q    <= 8'h00;
      tpar_q   <= 1'b0;
      tstop2_q <= 1'b0;
      tx_q     <= 1'b1;
    end else begin
      if (tick_q) tsub_q <= tsub_q + 4'h1;
      case (ts_q)
        S_IDLE: begin
          tx_q <= 1'b1;
          if (tx_load) begin
            ts_q   <= S_START;
            tsub_q <= 4'h0;
            tsh_q  <= tx_head & wm;
            tpar_q <= ^(tx_head & wm) ^ ~lcr_q[LCR_EVEN];
            tx_q   <= 1'b0;
          end
        end
        S_START: if (tbit_end) begin
          ts_q   <= S_DATA;
          tbit_q <= 3'h0;
          tx_q   <= tsh_q[0];
        end
        S_DATA: if (tbit_end) begin
          if (tbit_q == {1'b1, lcr_q[LCR_WLEN +: 2]}) begin
            ts_q     <= lcr_q[LCR_PEN] ? S_PAR : S_STOP;
            tx_q     <= lcr_q[LCR_PEN] ? tpar_q : 1'b1;
            tstop2_q <= lcr_q[LCR_STOP];
          end else begin
            tbit_q <= tbit_q + 3'h1;
            tx_q   <= tsh_q[tbit_q + 3'h1];
          end
        end
        S_PAR: if (tbit_end) begin
          ts_q <= S_STOP;
          tx_q <= 1'b1;
        end
        S_STOP: if (tbit_end) begin
          if (tstop2_q) tstop2_q <= 1'b0;
          else ts_q <= S_IDLE;
        end
        default: ts_q <= S_IDLE;
      endcase
    end
  end

  // Receive FIFO storage: data plus break, framing and parity tags
  always_ff @(posedge clock_i) begin
    if (rx_push) rxm_q[rwp_q] <= {brk_now, fe_now, rpe_q, rdat};
  end

  // Receive FIFO pointers and overrun; a new overrun beats its clear
  always_ff @(posedge clock_i) begin
    if (rst_i || rx_clr) begin
      rwp_q  <= '0;
      rrp_q  <= '0;
      rcnt_q <= '0;
    end else begin
      if (rx_push) rwp_q <= rwp_q + PW'(1);
      if (rx_pop)  rrp_q <= rrp_q + PW'(1);
      rcnt_q <= rcnt_q + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
    end
    if (rst_i)        ovr_q <= 1'b0;
    else if (ovr_set) ovr_q <= 1'b1;
    else if (ovr_clr) ovr_q <= 1'b0;
  end

  // Receive shifter: start checked at centre, later bits every 16 ticks
  always_ff @(posedge clock_i) begin
    if (rst_i || !div_on) begin
      rs_q   <= S_IDLE;
      rsub_q <= 4'h0;
      rbit_q <= 3'h0;
      rsh_q  <= 8'h00;
      rpe_q  <= 1'b0;
    end else begin
      if (tick_q) rsub_q <= rsub_q + 4'h1;
      case (rs_q)
        S_IDLE: if (tick_q && !rx_s2_q) begin
          rs_q   <= S_START;
          rsub_q <= 4'h0;
        end
        S_START: if (rmid) begin
          rsub_q <= 4'h0;
          rs_q   <= rx_s2_q ? S_IDLE : S_DATA;
          rbit_q <= 3'h0;
          rsh_q  <= 8'h00;
          rpe_q  <= 1'b0;
        end
        S_DATA: if (rsample) begin
          rsh_q[rbit_q] <= rx_s2_q;
          if (rbit_q == {1'b1, lcr_q[LCR_WLEN +: 2]})
            rs_q <= lcr_q[LCR_PEN] ? S_PAR : S_STOP;
          else
            rbit_q <= rbit_q + 3'h1;
        end
        S_PAR: if (rsample) begin
          rpe_q <= (^rdat ^ rx_s2_q) != ~lcr_q[LCR_EVEN];
          rs_q  <= S_STOP;
        end
        S_STOP: if (rsample) rs_q <= S_IDLE;
        default: rs_q <= S_IDLE;
      endcase
    end
  end

  // Receive timeout: restarts on every character in or out
  always_ff @(posedge clock_i) begin
    if (rst_i || !fifo_en || !rx_have || rx_push || rx_pop) begin
      tocnt_q <= 11'h000;
      tof_q   <= 1'b0;
    end else if (tick_q && !tof_q) begin
      if (tocnt_q >= tout_limit(lcr_q[LCR_WLEN +: 2]) - 11'h001)
        tof_q <= 1'b1;
      else
        tocnt_q <= tocnt_q + 11'h001;
    end
  end

  // Registered interrupt pin, high while any enabled source is pending
  always_ff @(posedge clock_i) begin
    if (rst_i) irq_q <= 1'b0;
    else irq_q <= isr_code != ISR_NONE;
  end

  assign prdata_o         = prdata_q;
  assign pready_o         = pready_q;
  assign pslverr_o        = pslverr_q;
  assign tx_o             = tx_q;
  assign chan_a_irq_pin_o = irq_q;

endmodule // uart_chan

// [rtl/uart_chan_pkg.sv]
// Package with register map, field layout and timing counts for one channel
package uart_chan_pkg;

  // Register byte offsets on the APB bus
  localparam logic [4:0] OFS_DATA = 5'h00; // tx write, rx read
  localparam logic [4:0] OFS_IER  = 5'h04;
  localparam logic [4:0] OFS_ISR  = 5'h08; // read isr, write fifo control
  localparam logic [4:0] OFS_LCR  = 5'h0C;
  localparam logic [4:0] OFS_LSR  = 5'h14;
  localparam logic [4:0] OFS_DLL  = 5'h18;
  localparam logic [4:0] OFS_DLM  = 5'h1C;

  // Reset values
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h03; // 8 data bits, no parity
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00; // baud generator halted

  // Interrupt enable bits
  localparam int IER_RXD = 0;
  localparam int IER_THE = 1;
  localparam int IER_RLS = 2;

  // FIFO control bits
  localparam int FCR_EN   = 0;
  localparam int FCR_RXRS = 1;
  localparam int FCR_TXRS = 2;
  localparam int FCR_TRG  = 6; // two bits, 7:6

  // Line control fields
  localparam int LCR_WLEN = 0; // two bits, 1:0
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN  = 3;
  localparam int LCR_EVEN = 4;

  // Receive trigger levels selected by the two trigger bits
  localparam logic [4:0] TRG_LVL0 = 5'h01;
  localparam logic [4:0] TRG_LVL1 = 5'h04;
  localparam logic [4:0] TRG_LVL2 = 5'h08;
  localparam logic [4:0] TRG_LVL3 = 5'h0E;

  // Interrupt status codes, highest priority first
  localparam logic [3:0] ISR_RLS  = 4'h6;
  localparam logic [3:0] ISR_RXD  = 4'h4;
  localparam logic [3:0] ISR_TOUT = 4'hC;
  localparam logic [3:0] ISR_THE  = 4'h2;
  localparam logic [3:0] ISR_NONE = 4'h1;

  // Sampling ticks per bit, tick of the bit centre, timeout extra bits
  localparam logic [3:0] TICKS_LAST = 4'hF; // 16 ticks per bit
  localparam logic [3:0] TICK_MID   = 4'h7; // 8th tick after edge
  localparam int         TOUT_WORDS = 4;
  localparam int         TOUT_EXTRA = 12;
  localparam int         TICKS_BIT  = 16;

endpackage

// [testbench/remote_serial.sv]
// Remote serial device: captures tx frames, sends rx frames
`timescale 1ns/1ps
module remote_serial #(
  parameter int BIT_NS = 320
) (
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] got_q;
  logic       par_q;
  logic       stop_q;
  int         count_q;
  // Sample at bit centres; fixed 8 data bits plus parity
  initial begin
    line_o = 1'b1;
    count_q = 0;
    forever begin
      @(negedge line_i);
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        got_q[i] = line_i;
      end
      #(BIT_NS) par_q = line_i;
      #(BIT_NS) stop_q = line_i;
      count_q++;
    end
  end
  // Stop is cut short so a low stop leaves no fake start edge
  task automatic send(input logic [7:0] d, input logic stop_ok);
    #1; // Keep line edges off the clock edge
    line_o = 1'b0;
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS) line_o = d[i];
    end
    #(BIT_NS) line_o = ^d;
    #(BIT_NS) line_o = stop_ok;
    #(BIT_NS * 5 / 8) line_o = 1'b1;
    #(BIT_NS);
  endtask
  // Low pulse far shorter than half a bit
  task automatic glitch();
    #1;
    line_o = 1'b0;
    #(BIT_NS / 8) line_o = 1'b1;
    #(BIT_NS);
  endtask
endmodule // remote_serial

// [testbench/uart_chan_assertions.sv]
// Checker for bus handshake, bit timing and interrupt masking
`timescale 1ns/1ps
module uart_chan_checker
  import uart_chan_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [4:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        tx_o,
  input wire logic        chan_a_irq_pin_o
);
  logic [2:0]  ier_q;
  logic [15:0] div_q;
  logic [5:0]  run_q;
  logic        wr_done;
  logic        mapped;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Completed writes and decoded offsets
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign mapped  = paddr_i inside {OFS_DATA, OFS_IER, OFS_ISR, OFS_LCR,
                                   OFS_LSR, OFS_DLL, OFS_DLM};
  // Shadows of enable and divisor, taken at the completing edge
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ier_q <= 3'h0;
      div_q <= 16'h0000;
    end else if (wr_done) begin
      if (paddr_i == OFS_IER) ier_q <= pwdata_i[2:0];
      if (paddr_i == OFS_DLL) div_q[7:0] <= pwdata_i[7:0];
      if (paddr_i == OFS_DLM) div_q[15:8] <= pwdata_i[7:0];
    end
  end
  // Cycles since tx moved; reset counts as a long idle run
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      run_q <= 6'h3F;
    end else if ($changed(tx_o)) begin
      run_q <= 6'h00;
    end else if (run_q != 6'h3F) begin
      run_q <= run_q + 6'h01;
    end
  end
  property p_rdy_next;
    psel_i && !penable_i |=> pready_o;
  endproperty
  property p_rdy_pulse;
    pready_o |=> !pready_o;
  endproperty
  property p_rdy_cause;
    pready_o |-> psel_i && penable_i && $past(psel_i);
  endproperty
  property p_err_unmap;
    pready_o && !mapped |-> pslverr_o;
  endproperty
  property p_err_map;
    pready_o && mapped |-> !pslverr_o;
  endproperty
  // Osc below half the clock: a bit spans 31 cycles or more
  property p_bit_len;
    $changed(tx_o) |-> run_q >= 6'h1E;
  endproperty
  property p_irq_mask;
    (ier_q == 3'h0) [*3] |-> !chan_a_irq_pin_o;
  endproperty
  property p_div_zero;
    (div_q == 16'h0000) [*3] |-> tx_o;
  endproperty
  a_rdy_next: assert property (p_rdy_next)
    else $error("No ready after setup");
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("Ready longer than one cycle");
  a_rdy_cause: assert property (p_rdy_cause)
    else $error("Ready outside an access");
  a_err_unmap: assert property (p_err_unmap)
    else $error("Unmapped access without error");
  a_err_map: assert property (p_err_map)
    else $error("Mapped access flagged as error");
  a_bit_len: assert property (p_bit_len)
    else $error("Serial bit too short");
  a_irq_mask: assert property (p_irq_mask)
    else $error("Interrupt pin high while all sources masked");
  a_div_zero: assert property (p_div_zero)
    else $error("Line moved with zero divisor");
  c_write: cover property (pready_o && pwrite_i);
  c_frame: cover property ($fell(tx_o));
  c_irq: cover property ($rose(chan_a_irq_pin_o));
endmodule // uart_chan_checker
bind uart_chan uart_chan_checker u_chk (.clock_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o,
  .tx_o, .chan_a_irq_pin_o);

// [testbench/tb_uart_channel_txrx_baud.sv]
// Self-checking bench for one serial channel behind APB
`timescale 1ns/1ps
module tb_uart_channel_txrx_baud
  import uart_chan_pkg::*;
;
  localparam logic [15:0] DIV_EX = 16'h0900; // about 1356 bit/s example at the 50 MHz oscillator
  logic        clock_i;
  logic        rst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [4:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        osc_in_pin_i;
  logic        osc_run;
  logic        rx_i;
  logic        tx_o;
  logic        irq_o;
  logic [7:0]  q;
  logic        err;
  int          miscompares;
  int          compares;
  uart_chan u_dut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .osc_in_pin_i(osc_in_pin_i), .rx_i(rx_i),
    .tx_o(tx_o), .chan_a_irq_pin_o(irq_o));
  remote_serial #(.BIT_NS(320)) u_remote (.line_i(tx_o), .line_o(rx_i));
  // 200 MHz clock; oscillator 50 MHz, gated to prove bus needs none
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    osc_in_pin_i = 1'b0;
    forever #10 osc_in_pin_i = osc_run & ~osc_in_pin_i;
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 8'h01, 8'h00);
    q = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [4:0] a,
                    input logic [7:0] m, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, e, q & m);
  endtask
  task automatic wait_for(input logic rx, input int n);
    int k;
    k = 0;
    while ((rx ? u_remote.count_q < n : irq_o !== 1'b1) && k < 4000) begin
      @(posedge clock_i);
      k++;
    end
    if (k >= 4000) chk("wait", 8'h01, 8'h00);
  endtask
  task automatic t_regs();
    rd("ier", OFS_IER, 8'hFF, IER_RST);
    rd("isr", OFS_ISR, 8'hFF, 8'h01);
    rd("lcr", OFS_LCR, 8'hFF, LCR_RST);
    rd("lsr", OFS_LSR, 8'h60, 8'h60);
    xfer(1'b0, 5'h10, 8'h00);
    chk("slverr", 8'h01, {7'h00, err});
    xfer(1'b1, OFS_DLM, DIV_EX[15:8]);
    xfer(1'b1, OFS_DLL, DIV_EX[7:0]);
    rd("dlm", OFS_DLM, 8'hFF, 8'h09);
    rd("dll", OFS_DLL, 8'hFF, 8'h00);
    xfer(1'b1, OFS_DLM, 8'h00);
  endtask
  // Byte waits on a zero divisor, then leaves once divisor is one
  task automatic t_tx();
    osc_run <= 1'b1;
    xfer(1'b1, OFS_LCR, 8'h1B);
    xfer(1'b1, OFS_DATA, 8'h5A);
    repeat (300) @(posedge clock_i);
    chk("tx_idle", 8'h01, {7'h00, tx_o});
    rd("lsr_hold", OFS_LSR, 8'h60, 8'h00);
    xfer(1'b1, OFS_DLL, 8'h01);
    repeat (40) @(posedge clock_i);
    rd("lsr_busy", OFS_LSR, 8'h60, 8'h20);
    xfer(1'b1, OFS_IER, 8'h02);
    repeat (2) @(posedge clock_i);
    chk("irq_the", 8'h01, {7'h00, irq_o});
    xfer(1'b1, OFS_IER, 8'h00);
    wait_for(1'b1, 1);
    chk("tx_byte", 8'h5A, u_remote.got_q);
    chk("tx_par", {7'h00, ^8'h5A}, {7'h00, u_remote.par_q});
    chk("tx_stop", 8'h01, {7'h00, u_remote.stop_q});
    repeat (60) @(posedge clock_i);
    rd("lsr_idle", OFS_LSR, 8'h60, 8'h60);
  endtask
  task automatic t_fifo();
    logic [7:0] tab [3] = '{8'h11, 8'hC3, 8'h80};
    xfer(1'b1, OFS_LCR, 8'h0F); // Two stop bits, odd parity
    xfer(1'b1, OFS_ISR, 8'h01);
    for (int i = 0; i < 3; i++) xfer(1'b1, OFS_DATA, tab[i]);
    rd("lsr_fifo", OFS_LSR, 8'h60, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wait_for(1'b1, 2 + i);
      chk("fifo_byte", tab[i], u_remote.got_q);
      chk("fifo_par", {7'h00, ~^tab[i]}, {7'h00, u_remote.par_q});
    end
    // Rest of first stop bit plus the whole second one
    repeat (130) @(posedge clock_i);
    rd("lsr_empty", OFS_LSR, 8'h60, 8'h60);
  endtask
  // Good byte, glitch, bad-stop byte, then idle into the timeout
  task automatic t_rx();
    xfer(1'b1, OFS_LCR, 8'h1B);
    xfer(1'b1, OFS_ISR, 8'h41);
    xfer(1'b1, OFS_IER, 8'h01);
    u_remote.send(8'hA7, 1'b1);
    repeat (100) @(posedge clock_i);
    chk("irq_below", 8'h00, {7'h00, irq_o});
    u_remote.glitch();
    u_remote.send(8'h5C, 1'b0);
    // Timeout is 2816 cycles after the push; must not fire early
    repeat (2000) @(posedge clock_i);
    chk("irq_early", 8'h00, {7'h00, irq_o});
    wait_for(1'b0, 0);
    rd("isr_tout", OFS_ISR, 8'hCF, 8'hCC);
    rd("lsr_head", OFS_LSR, 8'h1D, 8'h01);
    rd("rx_first", OFS_DATA, 8'hFF, 8'hA7);
    rd("lsr_next", OFS_LSR, 8'h1D, 8'h09);
    rd("rx_second", OFS_DATA, 8'hFF, 8'h5C);
    rd("lsr_drain", OFS_LSR, 8'h01, 8'h00);
    // FIFO off: a single byte raises the pin, reading it drops it
    xfer(1'b1, OFS_ISR, 8'h00);
    u_remote.send(8'h3C, 1'b1);
    wait_for(1'b0, 0);
    rd("isr_rxd", OFS_ISR, 8'hCF, 8'h04);
    rd("rx_single", OFS_DATA, 8'hFF, 8'h3C);
    repeat (2) @(posedge clock_i);
    chk("irq_empty", 8'h00, {7'h00, irq_o});
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    miscompares = 0;
    compares = 0;
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 5'h00;
    pwdata_i = 32'h00000000;
    osc_run = 1'b0;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    t_regs();
    t_tx();
    t_fifo();
    t_rx();
    end_sim();
  end
  // Watchdog well beyond the expected 10k cycles
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule // tb_uart_channel_txrx_baud
